//--- gauge_cmd_map.svh
// register offsets, field positions, reset values and timing counts
// Contract
// - state code 8 on any charger fault while not discharging
// - state code C on short or overload without hot or fail states
// - state code a on either discharge overcurrent tier
// - state code b on charge overtemperature
// - state code f when the pack is not present
// - state code d while asleep; any bus traffic wakes it
// - control commands act on write alone and return no data
// - control commands act only while unsealed
// - 0x0010 checks shutdown conditions then shuts down
// - 0x0011 enters sleep
// - 0x0021 starts gauging, sets enable flag, voltage-ok and update bits
// - update flags byte holds only bit 2, default 0x00
// - 0x2673 then 0x1712 clears failure, releases outputs, unlocks flash
// - any other transaction after the first word abandons the clear
// - first word ignored until 4 seconds after a failed attempt
// - 0x0030 drives protection low output low, high output high
// - 0x0031 releases protection unless held; failure mode unchanged
// - 0x0032 lights all configured LEDs until told otherwise
// - 0x0033 turns all configured LEDs off
// - 0x0034 shows charge level, blanked by normal display timeout
// - 0x0040 enters calibration mode
// - full reset command resets all, stretching the bus meanwhile
// - 0x0020 seals and sets the seal bit
`ifndef GAUGE_CMD_MAP_SVH
`define GAUGE_CMD_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFF_CMD 8'h00
`define OFF_STATUS 8'h04
`define OFF_UPDATE 8'h08

// ----------------------------------------------------------------
// command words
// ----------------------------------------------------------------
`define CMD_SHUTDOWN 16'h0010
`define CMD_SLEEP 16'h0011
`define CMD_SEAL 16'h0020
`define CMD_ALGO_EN 16'h0021
`define CMD_PFC_FIRST 16'h2673
`define CMD_PFC_SECOND 16'h1712
`define CMD_PROT_ON 16'h0030
`define CMD_PROT_OFF 16'h0031
`define CMD_LEDS_ON 16'h0032
`define CMD_LEDS_OFF 16'h0033
`define CMD_SOC_SHOW 16'h0034
`define CMD_CALIB 16'h0040
`define CMD_FULL_RESET 16'h0041

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define UPD_ALGO_BIT 2
`define UPD_VALID_MASK 8'h04
`define UPD_RESET 8'h00
`define SEALED_RESET 1'b1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ----------------------------------------------------------------
// pack state codes
// ----------------------------------------------------------------
`define CODE_NORMAL 4'h0
`define CODE_CHG_TERM 4'h8
`define CODE_PERM_FAIL 4'h9
`define CODE_DSG_FAIL 4'hA
`define CODE_HOT_CHG 4'hB
`define CODE_BATT_FAIL 4'hC
`define CODE_SLEEP 4'hD
`define CODE_REMOVED 4'hF

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_HZ 20000000
`define PFC_HOLDOFF_S 4
`define PFC_HOLDOFF_CYC (`PFC_HOLDOFF_S * `CLK_HZ)
`define FULL_RESET_US 3000
`define FULL_RESET_CYC ((`CLK_HZ / 1000000) * `FULL_RESET_US)

`endif

//--- gauge_cmd_pkg.sv
// types shared by the command decoder and the state encoder
package gauge_cmd_pkg;

    typedef struct packed {
        logic overchargeCurrentFlag;
        logic overchargeVoltageFlag;
        logic prechargeTimeoutFlag;
        logic fastchargeTimeoutFlag;
        logic overchargeFlag;
        logic excessLowvoltChargeFlag;
    } chg_flags_t;

    typedef struct packed {
        logic shortInChargeFlag;
        logic dischargeOverloadFlag;
        logic shortInDischargeFlag;
        logic chargeOvercurrentFlag;
        logic chargeOvercurrentTier2Flag;
        logic dischargeOvercurrentFlag;
        logic dischargeOvercurrentTier2Flag;
        logic chargeOvertempFlag;
        logic dischargeOvertempFlag;
    } safety_flags_t;

    typedef struct packed {
        chg_flags_t chg;
        safety_flags_t safety;
        logic dischargingFlag;
        logic packPresentBit;
    } gauge_flags_t;

    typedef enum logic [2:0] {
        PWR_NORMAL = 3'b001,
        PWR_SLEEP = 3'b010,
        PWR_SHUTDOWN = 3'b100
    } power_mode_t;

    typedef enum logic [2:0] {
        LED_OFF = 3'b001,
        LED_ALL_ON = 3'b010,
        LED_SOC = 3'b100
    } led_mode_t;

    typedef struct packed {
        logic sealedBit;
        logic voltageOkBit;
        logic capacityUpdateActiveBit;
        logic permanentFailureFlag;
        logic permFailStatus;
        logic flashUnlocked;
    } op_status_t;

    typedef struct packed {
        logic [7:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [7:0] araddr;
        logic arvalid;
        logic rready;
    } axil_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } axil_rsp_t;

    typedef struct packed {
        logic [3:0] code;
    } enc_state_t;

endpackage

//--- gauge_state_encoder.sv
// pack state code chosen from safety, charging and operation flags
`timescale 1ns/1ps
`include "gauge_cmd_map.svh"
module gauge_state_encoder (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // status sources
    input wire gauge_cmd_pkg::gauge_flags_t flags,
    input wire logic sleeping,
    input wire logic permFail,
    // code out
    output logic [3:0] stateCode
);
    import gauge_cmd_pkg::*;

    enc_state_t s;
    enc_state_t n;
    logic chgFault;
    logic battFail;

    // ----------------------------------------------------------------
    // priority encode
    // ----------------------------------------------------------------
    always_comb
    begin
        n = s;
        chgFault = |flags.chg;
        battFail = flags.safety.shortInChargeFlag
            || flags.safety.dischargeOverloadFlag
            || flags.safety.shortInDischargeFlag;
        if (!flags.packPresentBit)
            n.code = `CODE_REMOVED;
        else if (permFail)
            n.code = `CODE_PERM_FAIL;
        else if (sleeping)
            n.code = `CODE_SLEEP;
        else if (flags.safety.chargeOvertempFlag)
            n.code = `CODE_HOT_CHG;
        else if (flags.safety.dischargeOvercurrentFlag
            || flags.safety.dischargeOvercurrentTier2Flag)
            n.code = `CODE_DSG_FAIL;
        else if (battFail && !flags.safety.dischargeOvertempFlag
            && !flags.safety.chargeOvercurrentFlag
            && !flags.safety.chargeOvercurrentTier2Flag)
            n.code = `CODE_BATT_FAIL;
        else if (chgFault && !flags.dischargingFlag)
            n.code = `CODE_CHG_TERM;
        else
            n.code = `CODE_NORMAL;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            s <= '{code: `CODE_NORMAL};
        else
            s <= n;
    end

    assign stateCode = s.code;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    code_removed_a: assert property (@(posedge clk) disable iff (rst)
        !flags.packPresentBit |=> stateCode == `CODE_REMOVED)
        else $error("removed pack not coded f");
    code_charger_a: assert property (@(posedge clk) disable iff (rst)
        flags.packPresentBit && !permFail && !sleeping && !(|flags.safety)
        && (|flags.chg) && !flags.dischargingFlag
        |=> stateCode == `CODE_CHG_TERM)
        else $error("charger fault not coded 8");
endmodule

//--- gauge_system_command_decoder.sv
// system-control command decoder with AXI4-Lite register access
`timescale 1ns/1ps
`include "gauge_cmd_map.svh"
module gauge_system_command_decoder #(
    parameter int unsigned HOLDOFF_CYC = `PFC_HOLDOFF_CYC,
    parameter int unsigned RESET_CYC = `FULL_RESET_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register bus
    input wire gauge_cmd_pkg::axil_req_t busReq,
    output gauge_cmd_pkg::axil_rsp_t busRsp,
    // gauge status sources
    input wire gauge_cmd_pkg::gauge_flags_t flags,
    input wire logic shutdownAllowed,
    input wire logic protectHold,
    input wire logic permFailSet,
    input wire logic unsealPulse,
    input wire logic displayDone,
    input wire logic busActivity,
    // protection pair
    output logic protectDriveN,
    output logic protectDrive,
    // power, display and mode
    output gauge_cmd_pkg::power_mode_t powerMode,
    output gauge_cmd_pkg::led_mode_t ledMode,
    output logic calibrationMode,
    output logic busClockHold,
    output logic algoStartPulse,
    output logic coreResetPulse,
    // status
    output gauge_cmd_pkg::op_status_t opStatus,
    output logic [7:0] updateFlags,
    output logic [3:0] stateCode
);
    import gauge_cmd_pkg::*;

    typedef struct packed {
        logic awHeld;
        logic [7:0] awAddr;
        logic wHeld;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
        power_mode_t power;
        led_mode_t led;
        op_status_t op;
        logic [7:0] updFlags;
        logic calMode;
        logic protActive;
        logic armed;
        logic [31:0] holdoff;
        logic stretching;
        logic [31:0] resetCnt;
        logic algoPulse;
        logic resetPulse;
    } dec_state_t;

    localparam dec_state_t ST_RESET = '{
        awHeld: 1'b0, awAddr: 8'h00, wHeld: 1'b0, wData: 32'h0000_0000,
        wStrb: 4'h0, bValid: 1'b0, bResp: `RESP_OKAY, rValid: 1'b0,
        rData: 32'h0000_0000, rResp: `RESP_OKAY, power: PWR_NORMAL,
        led: LED_OFF,
        op: '{sealedBit: `SEALED_RESET, default: 1'b0},
        updFlags: `UPD_RESET, calMode: 1'b0, protActive: 1'b0,
        armed: 1'b0, holdoff: 32'h0000_0000, stretching: 1'b0,
        resetCnt: 32'h0000_0000, algoPulse: 1'b0, resetPulse: 1'b0
    };

    dec_state_t s;
    dec_state_t n;
    logic awReady;
    logic wReady;
    logic arReady;
    logic arFire;
    logic doWrite;
    logic cmdFire;
    logic cmdAct;
    logic [15:0] cmdWord;
    logic anyTxn;

    // ----------------------------------------------------------------
    // parameter checks
    // ----------------------------------------------------------------
    // the stall check below watches four cycles of stretch
    if (HOLDOFF_CYC < 1 || RESET_CYC < 4)
    begin : g_bad_params
        $error("holdoff must be at least 1 and reset at least 4 cycles");
    end

    // ----------------------------------------------------------------
    // bus handshakes
    // ----------------------------------------------------------------
    // the bus stalls while a full reset runs, which stands in for the
    // clock stretch on the serial link
    assign awReady = !s.awHeld && !s.stretching;
    assign wReady = !s.wHeld && !s.stretching;
    assign arReady = !s.rValid && !s.stretching;
    assign arFire = busReq.arvalid && arReady;
    assign doWrite = s.awHeld && s.wHeld && !s.bValid && !s.stretching;
    assign cmdFire = doWrite && s.awAddr == `OFF_CMD
        && s.wStrb[1:0] == 2'b11;
    assign cmdWord = s.wData[15:0];
    assign cmdAct = cmdFire && !s.op.sealedBit;
    assign anyTxn = doWrite || arFire;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        n = s;
        n.algoPulse = 1'b0;
        n.resetPulse = 1'b0;
        if (busReq.awvalid && awReady)
        begin
            n.awHeld = 1'b1;
            n.awAddr = busReq.awaddr;
        end
        if (busReq.wvalid && wReady)
        begin
            n.wHeld = 1'b1;
            n.wData = busReq.wdata;
            n.wStrb = busReq.wstrb;
        end
        if (s.bValid && busReq.bready)
            n.bValid = 1'b0;
        if (s.rValid && busReq.rready)
            n.rValid = 1'b0;
        if (s.holdoff != 32'h0000_0000)
            n.holdoff = s.holdoff - 32'h0000_0001;
        if (displayDone && s.led == LED_SOC)
            n.led = LED_OFF;
        if (unsealPulse)
            n.op.sealedBit = 1'b0;
        if (s.power == PWR_SLEEP && (anyTxn || busActivity))
            n.power = PWR_NORMAL;
        if (arFire)
        begin
            n.rValid = 1'b1;
            n.rResp = `RESP_OKAY;
            case (busReq.araddr)
                `OFF_CMD: n.rData = 32'h0000_0000;
                `OFF_STATUS: n.rData = {10'h000, s.armed,
                    s.holdoff != 32'h0000_0000, s.calMode, s.protActive,
                    s.power, s.led, 2'b00, s.op, stateCode};
                `OFF_UPDATE: n.rData = {24'h00_0000, s.updFlags};
                default:
                begin
                    n.rData = 32'h0000_0000;
                    n.rResp = `RESP_SLVERR;
                end
            endcase
        end
        if (doWrite)
        begin
            n.awHeld = 1'b0;
            n.wHeld = 1'b0;
            n.bValid = 1'b1;
            n.bResp = `RESP_OKAY;
            case (s.awAddr)
                `OFF_CMD, `OFF_STATUS: n.bResp = `RESP_OKAY;
                `OFF_UPDATE:
                begin
                    if (s.wStrb[0] && !s.op.sealedBit)
                        n.updFlags = s.wData[7:0] & `UPD_VALID_MASK;
                end
                default: n.bResp = `RESP_SLVERR;
            endcase
        end
        if (s.armed && anyTxn
            && !(cmdAct && cmdWord == `CMD_PFC_SECOND))
        begin
            n.armed = 1'b0;
            n.holdoff = HOLDOFF_CYC;
        end
        if (cmdAct)
        begin
            case (cmdWord)
                `CMD_SHUTDOWN:
                    if (shutdownAllowed)
                        n.power = PWR_SHUTDOWN;
                `CMD_SLEEP: n.power = PWR_SLEEP;
                `CMD_SEAL: n.op.sealedBit = 1'b1;
                `CMD_ALGO_EN:
                begin
                    n.algoPulse = 1'b1;
                    n.updFlags[`UPD_ALGO_BIT] = 1'b1;
                    n.op.voltageOkBit = 1'b1;
                    n.op.capacityUpdateActiveBit = 1'b1;
                end
                `CMD_PFC_FIRST:
                    if (s.holdoff == 32'h0000_0000 && !s.armed)
                        n.armed = 1'b1;
                `CMD_PFC_SECOND:
                    if (s.armed)
                    begin
                        n.armed = 1'b0;
                        n.op.permanentFailureFlag = 1'b0;
                        n.op.permFailStatus = 1'b0;
                        n.op.flashUnlocked = 1'b1;
                        n.protActive = 1'b0;
                    end
                `CMD_PROT_ON: n.protActive = 1'b1;
                `CMD_PROT_OFF:
                    if (!protectHold)
                        n.protActive = 1'b0;
                `CMD_LEDS_ON: n.led = LED_ALL_ON;
                `CMD_LEDS_OFF: n.led = LED_OFF;
                `CMD_SOC_SHOW: n.led = LED_SOC;
                `CMD_CALIB: n.calMode = 1'b1;
                `CMD_FULL_RESET:
                begin
                    n.bValid = 1'b0;
                    n.stretching = 1'b1;
                    n.resetCnt = RESET_CYC - 1;
                end
                default: n.calMode = s.calMode;
            endcase
        end
        // a failure raised in the same cycle as a clear must survive
        if (permFailSet)
        begin
            n.op.permanentFailureFlag = 1'b1;
            n.op.permFailStatus = 1'b1;
            n.protActive = 1'b1;
        end
        if (protectHold)
            n.protActive = 1'b1;
        if (s.stretching)
        begin
            if (s.resetCnt == 32'h0000_0000)
            begin
                n = ST_RESET;
                // an answer taken in this very cycle must not repeat
                n.rValid = s.rValid && !busReq.rready;
                n.rData = s.rData;
                n.rResp = s.rResp;
                n.bValid = 1'b1;
                n.resetPulse = 1'b1;
                // failure and hold still win over the reset values
                n.protActive = protectHold || permFailSet;
                n.op.permanentFailureFlag = permFailSet;
                n.op.permFailStatus = permFailSet;
            end
            else
                n.resetCnt = s.resetCnt - 32'h0000_0001;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            s <= ST_RESET;
        else
            s <= n;
    end

    // ----------------------------------------------------------------
    // state code
    // ----------------------------------------------------------------
    gauge_state_encoder u_encoder (
        .clk(clk),
        .rst(rst),
        .flags(flags),
        .sleeping(s.power == PWR_SLEEP),
        .permFail(s.op.permanentFailureFlag),
        .stateCode(stateCode)
    );

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign busRsp.awready = awReady;
    assign busRsp.wready = wReady;
    assign busRsp.bvalid = s.bValid;
    assign busRsp.bresp = s.bResp;
    assign busRsp.arready = arReady;
    assign busRsp.rvalid = s.rValid;
    assign busRsp.rdata = s.rData;
    assign busRsp.rresp = s.rResp;
    assign protectDriveN = !s.protActive;
    assign protectDrive = s.protActive;
    assign powerMode = s.power;
    assign ledMode = s.led;
    assign calibrationMode = s.calMode;
    assign busClockHold = s.stretching;
    assign algoStartPulse = s.algoPulse;
    assign coreResetPulse = s.resetPulse;
    assign opStatus = s.op;
    assign updateFlags = s.updFlags;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sealed_no_effect_a: assert property (@(posedge clk)
        disable iff (rst)
        cmdFire && s.op.sealedBit && !displayDone
        |=> ledMode == $past(ledMode) && calibrationMode == $past(s.calMode))
        else $error("sealed command changed state");
    sleep_entry_a: assert property (@(posedge clk) disable iff (rst)
        cmdAct && cmdWord == `CMD_SLEEP |=> powerMode == PWR_SLEEP)
        else $error("sleep command ignored");
    sleep_wake_a: assert property (@(posedge clk) disable iff (rst)
        s.power == PWR_SLEEP && arFire
        && !(cmdAct && (cmdWord == `CMD_SLEEP || cmdWord == `CMD_SHUTDOWN))
        |=> powerMode == PWR_NORMAL)
        else $error("traffic did not wake from sleep");
    prot_on_a: assert property (@(posedge clk) disable iff (rst)
        cmdAct && cmdWord == `CMD_PROT_ON
        |=> !protectDriveN && protectDrive)
        else $error("protection pair not asserted");
    prot_held_a: assert property (@(posedge clk) disable iff (rst)
        protectHold |=> protectDrive && !protectDriveN)
        else $error("held protection released");
    clear_abort_a: assert property (@(posedge clk) disable iff (rst)
        s.armed && arFire |=> !s.armed && s.holdoff == HOLDOFF_CYC)
        else $error("clear not abandoned on other traffic");
    clear_holdoff_a: assert property (@(posedge clk) disable iff (rst)
        s.holdoff != 32'h0000_0000 |=> !$rose(s.armed))
        else $error("first code taken during holdoff");
    clear_done_a: assert property (@(posedge clk) disable iff (rst)
        s.armed && cmdAct && cmdWord == `CMD_PFC_SECOND && !permFailSet
        && !protectHold
        |=> !opStatus.permanentFailureFlag && opStatus.flashUnlocked
        && protectDriveN)
        else $error("two-word clear incomplete");
    upd_bits_a: assert property (@(posedge clk) disable iff (rst)
        (updateFlags & ~`UPD_VALID_MASK) == 8'h00)
        else $error("reserved update flag bit set");
    reset_stall_a: assert property (@(posedge clk) disable iff (rst)
        cmdAct && cmdWord == `CMD_FULL_RESET
        |=> busClockHold && !busRsp.bvalid ##1 busClockHold[*3])
        else $error("full reset did not stall the bus");
    algo_start_a: assert property (@(posedge clk) disable iff (rst)
        cmdAct && cmdWord == `CMD_ALGO_EN
        |=> algoStartPulse && updateFlags[`UPD_ALGO_BIT]
        && opStatus.voltageOkBit && opStatus.capacityUpdateActiveBit)
        else $error("gauging start incomplete");
    clear_seen_c: cover property (@(posedge clk) disable iff (rst)
        s.armed && cmdAct && cmdWord == `CMD_PFC_SECOND);
    sleep_wake_c: cover property (@(posedge clk) disable iff (rst)
        s.power == PWR_SLEEP ##[1:20] s.power == PWR_NORMAL);
    reset_done_c: cover property (@(posedge clk) disable iff (rst)
        coreResetPulse);
endmodule

//--- gauge_host_model.sv
// bus master model standing for the system host
`timescale 1ns/1ps
module gauge_host_model (
    // clock
    input wire logic clk,
    // register bus
    output gauge_cmd_pkg::axil_req_t busReq,
    input wire gauge_cmd_pkg::axil_rsp_t busRsp
);
    import gauge_cmd_pkg::*;
    initial busReq = '0;
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        busReq.awaddr <= a;
        busReq.wdata <= d;
        busReq.wstrb <= 4'hF;
        busReq.awvalid <= 1'b1;
        busReq.wvalid <= 1'b1;
        busReq.bready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (busRsp.awready) busReq.awvalid <= 1'b0;
            if (busRsp.wready) busReq.wvalid <= 1'b0;
            // a released word is scrambled so nothing leans on it
            if (busRsp.wready) busReq.wdata <= ~d;
            if (busRsp.bvalid) busReq.bready <= 1'b0;
        end
        while (!(busRsp.bvalid && busReq.bready));
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        busReq.araddr <= a;
        busReq.arvalid <= 1'b1;
        busReq.rready <= 1'b1;
        do
        begin
            @(posedge clk);
            if (busRsp.arready) busReq.arvalid <= 1'b0;
            if (busRsp.rvalid) busReq.rready <= 1'b0;
        end
        while (!(busRsp.rvalid && busReq.rready));
    endtask
endmodule

//--- gauge_system_command_decoder_test.sv
// self-checking bench for the system command decoder
`timescale 1ns/1ps
module gauge_system_command_decoder_test;
    import gauge_cmd_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    axil_req_t busReq;
    axil_rsp_t busRsp;
    gauge_flags_t flags = '0;
    logic pfSet = 1'b0;
    logic unseal = 1'b0;
    logic wake = 1'b0;
    logic shutOk = 1'b0;
    logic hold = 1'b0;
    logic dispDone = 1'b0;
    wire [25:0] outs;
    logic [3:0] stateCode;
    logic [65:0] expQ[$];
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    int seed = 17;
    int k;
    int r;
    int lo[5] = '{11, 8, 4, 3, 2};
    int span[5] = '{6, 3, 2, 1, 15};
    logic [3:0] codes[5] = '{4'h8, 4'hC, 4'hA, 4'hB, 4'hF};
    logic [15:0] cmds[7] = '{16'h0032, 16'h0034, 16'h0033, 16'h0030,
        16'h0031, 16'h0040, 16'h0021};
    logic [31:0] m[7] = '{32'h7000, 32'h7000, 32'h7000, 32'h40000,
        32'h40000, 32'h80000, 32'h180};
    logic [31:0] v[7] = '{32'h2000, 32'h4000, 32'h1000, 32'h40000,
        32'h0, 32'h80000, 32'h180};
    gauge_host_model host (.clk(clk), .busReq(busReq), .busRsp(busRsp));
    gauge_system_command_decoder #(.HOLDOFF_CYC(20), .RESET_CYC(8)) dut (
        .clk(clk), .rst(rst), .busReq(busReq), .busRsp(busRsp),
        .flags(flags), .shutdownAllowed(shutOk), .protectHold(hold),
        .permFailSet(pfSet), .unsealPulse(unseal), .displayDone(dispDone),
        .busActivity(wake), .protectDriveN(outs[25]),
        .protectDrive(outs[24]), .powerMode(outs[23:21]),
        .ledMode(outs[20:18]), .calibrationMode(outs[17]),
        .busClockHold(outs[16]), .algoStartPulse(outs[15]),
        .coreResetPulse(outs[14]), .opStatus(outs[13:8]),
        .updateFlags(outs[7:0]), .stateCode(stateCode));
    task automatic stop_test;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic same(input logic [3:0] e, input logic [3:0] s);
        comparisons++;
        if (s !== e)
        begin
            failures++;
            $display("MISMATCH stateCode expected %h seen %h", e, s);
        end
    endtask
    task automatic pins(input logic [25:0] e);
        comparisons++;
        if (outs !== e)
        begin
            failures++;
            $display("MISMATCH outputs expected %h seen %h", e, outs);
        end
    endtask
    task automatic got(input logic [65:0] q);
        logic [33:0] s;
        s = {busRsp.rresp, busRsp.rdata & q[63:32]};
        comparisons++;
        if (s !== {q[65:64], q[31:0]})
        begin
            failures++;
            $display("MISMATCH read expected %h seen %h", q[65:0], s);
        end
    endtask
    task automatic chk(input logic [7:0] a, input logic [1:0] e,
        input logic [31:0] mk, input logic [31:0] val);
        expQ.push_back({e, mk, val});
        host.rd(a);
    endtask
    task automatic st(input logic [31:0] mk, input logic [31:0] val);
        chk(8'h04, 2'h0, mk, val);
    endtask
    task automatic cmd(input logic [15:0] w);
        host.wr(8'h00, {16'h0000, w});
    endtask
    initial forever #25 clk = ~clk;
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (busRsp.rvalid && busReq.rready) got(expQ.pop_front());
        if (cycles == 5000)
        begin
            failures++;
            stop_test;
        end
    end
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        st(32'h3FFFFF, 32'h920F);
        chk(8'h08, 2'h0, 32'hFF, 32'h0);
        chk(8'h00, 2'h0, 32'hFFFFFFFF, 32'h0);
        chk(8'h0C, 2'h2, 32'hFFFFFFFF, 32'h0);
        cmd(16'h0032);
        st(32'h7000, 32'h1000);
        $display("test sealed finished");
        flags.packPresentBit <= 1'b1;
        @(posedge clk) unseal <= 1'b1;
        @(posedge clk) unseal <= 1'b0;
        host.wr(8'h08, 32'hFB);
        chk(8'h08, 2'h0, 32'hFF, 32'h0);
        for (k = 0; k < 7; k++)
        begin
            cmd(cmds[k]);
            st(m[k], v[k]);
        end
        chk(8'h08, 2'h0, 32'hFF, 32'h04);
        pins(26'h2261804);
        @(posedge clk) hold <= 1'b1;
        cmd(16'h0031);
        st(32'h40000, 32'h40000);
        hold <= 1'b0;
        cmd(16'h0031);
        st(32'h40000, 32'h0);
        cmd(16'h0034);
        @(posedge clk) dispDone <= 1'b1;
        @(posedge clk) dispDone <= 1'b0;
        st(32'h7000, 32'h1000);
        cmd(16'h0011);
        repeat (2) @(posedge clk);
        same(4'hD, stateCode);
        @(posedge clk) wake <= 1'b1;
        @(posedge clk) wake <= 1'b0;
        repeat (2) @(posedge clk);
        same(4'h0, stateCode);
        cmd(16'h0011);
        st(32'h38000, 32'h10000);
        @(posedge clk);
        same(4'h0, stateCode);
        $display("test commands finished");
        @(posedge clk) pfSet <= 1'b1;
        @(posedge clk) pfSet <= 1'b0;
        cmd(16'h2673);
        cmd(16'h1712);
        st(32'h40070, 32'h10);
        @(posedge clk) pfSet <= 1'b1;
        @(posedge clk) pfSet <= 1'b0;
        cmd(16'h2673);
        cmd(16'h0033);
        cmd(16'h1712);
        st(32'h300040, 32'h100040);
        cmd(16'h2673);
        cmd(16'h1712);
        st(32'h40, 32'h40);
        repeat (30) @(posedge clk);
        cmd(16'h2673);
        st(32'h200000, 32'h200000);
        repeat (30) @(posedge clk);
        cmd(16'h2673);
        cmd(16'h1712);
        st(32'h40, 32'h0);
        $display("test failure clear finished");
        for (k = 0; k < 5; k++)
        begin
            r = $unsigned($random(seed)) % span[k];
            @(posedge clk)
                flags <= gauge_flags_t'(17'(1 << (lo[k] + r) | (k < 4)));
            repeat (3) @(posedge clk);
            same(codes[k], stateCode);
        end
        cmd(16'h0041);
        st(32'h200, 32'h200);
        @(posedge clk) unseal <= 1'b1;
        @(posedge clk) unseal <= 1'b0;
        shutOk <= 1'b1;
        cmd(16'h0010);
        st(32'h38000, 32'h20000);
        pins(26'h2840000);
        $display("test codes and power finished");
        stop_test;
    end
endmodule
